// ---- sdms_ctrl_model.sv ----
// model of the external controller issuing enable, step and direction
// assumes requests only while idle; step high 2 and low 2 clocks
`timescale 1ns/1ns
module sdms_ctrl_model (
   input wire logic clk,
   input wire logic nrst,
   input wire logic en,
   input wire logic dir,
   input wire logic req,
   input wire logic [7:0] n,
   output logic drive_allow,
   output logic step_pulse,
   output logic rot_cw,
   output logic busy
);
   logic [7:0] cnt;
   logic [1:0] ph;
   assign drive_allow = en;
   assign rot_cw = dir;
   assign busy = cnt != 8'h00;
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cnt <= 8'h00;
         ph <= 2'h0;
         step_pulse <= 1'b0;
      end else if (req && cnt == 8'h00) begin
         cnt <= n;
         ph <= 2'h0;
      end else if (cnt != 8'h00) begin
         // one rising edge per requested step
         step_pulse <= ph < 2'h2;
         ph <= ph + 2'h1;
         if (ph == 2'h3) begin
            cnt <= cnt - 8'h01;
         end
      end
   end
endmodule

// ---- sdms_pkg.sv ----
// constants shared by the step/direction coil sequencer
// assumes a 20 MHz system clock and an APB register bus
package sdms_pkg;
   localparam int CLK_HZ = 20000000;
   localparam int BAUD_HZ = 9600;
   localparam int BIT_CYC = CLK_HZ / BAUD_HZ;
   // register byte offsets
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_RATE = 8'h04;
   localparam logic [7:0] ADDR_SCALE = 8'h08;
   localparam logic [7:0] ADDR_SUBSTEP = 8'h0C;
   localparam logic [7:0] ADDR_STATUS = 8'h10;
   // ctrl fields
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_STORE_BIT = 2;
   // step_pattern_select codes
   localparam logic [1:0] MODE_FULL = 2'h0;
   localparam logic [1:0] MODE_HALF = 2'h1;
   localparam logic [1:0] MODE_MICRO = 2'h2;
   // reset values and limits
   localparam logic [15:0] RATE_RST = 16'h0BB8;
   localparam logic [15:0] RATE_MAX = 16'h4E20;
   localparam logic [15:0] RATE_MIN = 16'h0064;
   localparam logic [15:0] SCALE_RST = 16'h0D05;
   localparam logic [15:0] SCALE_MAX = 16'h2710;
   localparam logic [7:0] SUB_RST = 8'h08;
   // serial frame: index byte, data high byte, data low byte
   localparam int CFG_W = 42;
   localparam int DIV_W = 36;
   localparam logic [35:0] QUARTER_TURN = 36'h000010000;
   typedef enum logic [1:0] {DV_IDLE, DV_PER, DV_FS, DV_INC} sdms_div_e;
endpackage

// ---- sdms_top.sv ----
// two-coil bipolar stepper sequencer with coil pwm, apb and serial config
// assumes synchronous inputs to clk, an external nonvolatile store port
//
// Notes on behaviour
// - coil drive is off while drive_allow is low, allowed while high.
// - every rising step_pulse edge while drive_allow is high moves the motor exactly one position.
// - rotation sense low steps counterclockwise, high steps clockwise.
// - full, half and microstep patterns; full step after reset.
// - coil switch rate set in Hz, default 3000, up to 20 kHz.
// - effective switch rate may differ from the setting to limit current.
// - current scale factor 10000 means 3 A; default 3333 about 1 A.
// - substeps per full step only 8,12,16,20,24,128; used in microstep.
// - store request writes settings to nonvolatile memory for restore.
// - settings also arrive over an asynchronous serial rx/tx link.
// - default configuration limits each coil to 1 A.
// - half step alternates two-coil positions with one-coil positions.
`timescale 1ns/1ns
module sdms_top import sdms_pkg::*; #(
   parameter int BIT_CYCLES = BIT_CYC
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic drive_allow,
   input wire logic step_pulse,
   input wire logic rot_cw,
   input wire logic rx_line,
   output logic tx_line,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic nv_valid,
   input wire logic [CFG_W-1:0] nv_rdata,
   output logic nv_we,
   output logic [CFG_W-1:0] nv_wdata,
   output logic drive_on,
   output logic coil_a_pwm,
   output logic coil_a_neg,
   output logic coil_b_pwm,
   output logic coil_b_neg
);
   initial begin
      if (BIT_CYCLES < 8 || BIT_CYCLES > 4095) begin
         $error("BIT_CYCLES out of range");
      end
   end

   function automatic logic sub_ok(input logic [15:0] v);
      case (v)
         16'h0008, 16'h000C, 16'h0010, 16'h0014, 16'h0018,
         16'h0080: sub_ok = 1'b1;
         default: sub_ok = 1'b0;
      endcase
   endfunction

   // quarter sine, 16 points, full scale 255
   function automatic logic [7:0] sin_q(input logic [4:0] f);
      case (f)
         5'h00: sin_q = 8'h00;
         5'h01: sin_q = 8'h19;
         5'h02: sin_q = 8'h32;
         5'h03: sin_q = 8'h4A;
         5'h04: sin_q = 8'h62;
         5'h05: sin_q = 8'h78;
         5'h06: sin_q = 8'h8E;
         5'h07: sin_q = 8'hA2;
         5'h08: sin_q = 8'hB4;
         5'h09: sin_q = 8'hC5;
         5'h0A: sin_q = 8'hD4;
         5'h0B: sin_q = 8'hE1;
         5'h0C: sin_q = 8'hEC;
         5'h0D: sin_q = 8'hF4;
         5'h0E: sin_q = 8'hFA;
         5'h0F: sin_q = 8'hFE;
         default: sin_q = 8'hFF;
      endcase
   endfunction

   // sign and magnitude of sin over a full turn: quadrant and fraction
   function automatic logic [8:0] coil_val(input logic [1:0] q,
                                           input logic [3:0] f);
      logic [7:0] m;
      m = q[0] ? sin_q(5'h10 - {1'b0, f}) : sin_q({1'b0, f});
      coil_val = {q[1], m};
   endfunction

   // half-step pattern {a_on, a_neg, b_on, b_neg}; odd positions energise both
   function automatic logic [3:0] half_pat(input logic [2:0] h);
      case (h)
         3'h0: half_pat = 4'b1000;
         3'h1: half_pat = 4'b1010;
         3'h2: half_pat = 4'b0010;
         3'h3: half_pat = 4'b1110;
         3'h4: half_pat = 4'b1100;
         3'h5: half_pat = 4'b1111;
         3'h6: half_pat = 4'b0011;
         3'h7: half_pat = 4'b1011;
         default: half_pat = 4'b0000;
      endcase
   endfunction

   // ---------------- input sync, config, apb ----------------
   logic [3:0] s1_r, s2_r;
   logic step_d_r, restore_r, dirty_r, pready_r, pslverr_r, nv_we_r;
   logic [1:0] mode_r, mode_nxt;
   logic [15:0] rate_r, rate_nxt, scale_r, scale_nxt;
   logic [7:0] sub_r, sub_nxt;
   logic [31:0] prdata_r, prdata_nxt;
   logic [CFG_W-1:0] nv_wdata_r, nv_wdata_nxt;
   logic dirty_nxt, pready_nxt, pslverr_nxt, nv_we_nxt;
   logic wr_en, wr_store, apb_wr, step_acc;
   logic [1:0] wr_idx;
   logic [15:0] wr_data;
   logic ser_wr;
   logic [1:0] ser_idx;
   logic [15:0] ser_data;
   logic [8:0] idx_r;
   logic dv_busy;

   assign apb_wr = psel & penable & pready_r & pwrite & ~pslverr_r & ~paddr[4];
   // rising edge on the second sync stage while drive is allowed
   assign step_acc = s2_r[1] & ~step_d_r & s2_r[0];

   always_comb begin
      // apb write wins over a serial write landing in the same cycle
      wr_en = apb_wr | ser_wr;
      wr_idx = apb_wr ? paddr[3:2] : ser_idx;
      wr_data = apb_wr ? pwdata[15:0] : ser_data;
      wr_store = wr_en && wr_idx == ADDR_CTRL[3:2] &&
                 wr_data[CTRL_STORE_BIT];
      mode_nxt = mode_r;
      rate_nxt = rate_r;
      scale_nxt = scale_r;
      sub_nxt = sub_r;
      if (restore_r && nv_valid) begin
         {mode_nxt, rate_nxt, scale_nxt, sub_nxt} = nv_rdata;
      end else if (wr_en) begin
         case (wr_idx)
            2'h0: begin
               if (wr_data[1:0] != 2'h3) begin
                  mode_nxt = wr_data[1:0];
               end
            end
            2'h1: rate_nxt = wr_data;
            2'h2: scale_nxt = wr_data;
            default: begin
               if (sub_ok(wr_data)) begin
                  sub_nxt = wr_data[7:0];
               end
            end
         endcase
      end
      // a config write during a running division re-arms it
      dirty_nxt = (wr_en | restore_r) ? 1'b1 : (dirty_r & dv_busy);
      nv_we_nxt = wr_store;
      nv_wdata_nxt = wr_store ? {mode_nxt, rate_nxt, scale_nxt, sub_nxt}
                              : nv_wdata_r;
      pready_nxt = psel & ~penable;
      pslverr_nxt = psel & ~penable &
                    (paddr[1:0] != 2'h0 || paddr > ADDR_STATUS);
      prdata_nxt = 32'h00000000;
      if (psel && !penable) begin
         case (paddr)
            ADDR_CTRL: prdata_nxt = {30'h00000000, mode_r};
            ADDR_RATE: prdata_nxt = {16'h0000, rate_r};
            ADDR_SCALE: prdata_nxt = {16'h0000, scale_r};
            ADDR_SUBSTEP: prdata_nxt = {24'h000000, sub_r};
            ADDR_STATUS: prdata_nxt = {20'h00000, dv_busy, s2_r[2],
                                       s2_r[0], idx_r};
            default: prdata_nxt = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         // allow starts low so no drive glitch follows reset
         s1_r <= 4'hE;
         s2_r <= 4'hE;
         step_d_r <= 1'b1;
         restore_r <= 1'b1;
         dirty_r <= 1'b1;
         mode_r <= MODE_FULL;
         rate_r <= RATE_RST;
         scale_r <= SCALE_RST;
         sub_r <= SUB_RST;
         prdata_r <= 32'h00000000;
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         nv_we_r <= 1'b0;
         nv_wdata_r <= '0;
      end else begin
         s1_r <= {rx_line, rot_cw, step_pulse, drive_allow};
         s2_r <= s1_r;
         step_d_r <= s2_r[1];
         restore_r <= 1'b0;
         dirty_r <= dirty_nxt;
         mode_r <= mode_nxt;
         rate_r <= rate_nxt;
         scale_r <= scale_nxt;
         sub_r <= sub_nxt;
         prdata_r <= prdata_nxt;
         pready_r <= pready_nxt;
         pslverr_r <= pslverr_nxt;
         nv_we_r <= nv_we_nxt;
         nv_wdata_r <= nv_wdata_nxt;
      end
   end

   // ---------------- serial link: 8N1, 3-byte frames ----------------
   logic rx_busy_r, rx_busy_nxt, tx_busy_r, tx_busy_nxt, tx_r, tx_nxt;
   logic [11:0] rx_cnt_r, rx_cnt_nxt, tx_cnt_r, tx_cnt_nxt;
   logic [3:0] rx_bit_r, rx_bit_nxt, tx_bit_r, tx_bit_nxt;
   logic [7:0] rx_sh_r, rx_sh_nxt, fr_idx_r, fr_idx_nxt, fr_hi_r, fr_hi_nxt;
   logic [1:0] fr_pos_r, fr_pos_nxt;
   logic [9:0] tx_sh_r, tx_sh_nxt;
   logic ack_req;
   localparam logic [11:0] BITC = 12'(BIT_CYCLES - 1);
   localparam logic [11:0] HALFC = 12'(BIT_CYCLES / 2);

   always_comb begin
      rx_busy_nxt = rx_busy_r;
      rx_cnt_nxt = rx_cnt_r;
      rx_bit_nxt = rx_bit_r;
      rx_sh_nxt = rx_sh_r;
      fr_idx_nxt = fr_idx_r;
      fr_hi_nxt = fr_hi_r;
      fr_pos_nxt = fr_pos_r;
      ser_wr = 1'b0;
      ack_req = 1'b0;
      if (!rx_busy_r) begin
         if (!s2_r[3]) begin
            rx_busy_nxt = 1'b1;
            rx_cnt_nxt = HALFC;
            rx_bit_nxt = 4'h0;
         end
      end else if (rx_cnt_r != 12'h000) begin
         rx_cnt_nxt = rx_cnt_r - 12'h001;
      end else begin
         rx_cnt_nxt = BITC;
         rx_bit_nxt = rx_bit_r + 4'h1;
         if (rx_bit_r == 4'h0 && s2_r[3]) begin
            rx_busy_nxt = 1'b0;
         end else if (rx_bit_r >= 4'h1 && rx_bit_r <= 4'h8) begin
            rx_sh_nxt = {s2_r[3], rx_sh_r[7:1]};
         end else if (rx_bit_r == 4'h9) begin
            rx_busy_nxt = 1'b0;
            if (s2_r[3]) begin
               fr_pos_nxt = (fr_pos_r == 2'h2) ? 2'h0 : fr_pos_r + 2'h1;
               if (fr_pos_r == 2'h0) begin
                  fr_idx_nxt = rx_sh_r;
               end else if (fr_pos_r == 2'h1) begin
                  fr_hi_nxt = rx_sh_r;
               end else begin
                  ser_wr = fr_idx_r[7:2] == 6'h00;
                  ack_req = 1'b1;
               end
            end
         end
      end
      ser_idx = fr_idx_r[1:0];
      ser_data = {fr_hi_r, rx_sh_r};
      tx_busy_nxt = tx_busy_r;
      tx_cnt_nxt = tx_cnt_r;
      tx_bit_nxt = tx_bit_r;
      tx_sh_nxt = tx_sh_r;
      tx_nxt = tx_r;
      if (!tx_busy_r) begin
         tx_nxt = 1'b1;
         if (ack_req) begin
            // ack echoes the index byte, with bit 7 set if it was refused
            tx_busy_nxt = 1'b1;
            tx_sh_nxt = {1'b1, fr_idx_r[7:2] != 6'h00, fr_idx_r[6:0], 1'b0};
            tx_cnt_nxt = BITC;
            tx_bit_nxt = 4'h0;
            tx_nxt = 1'b0;
         end
      end else if (tx_cnt_r != 12'h000) begin
         tx_cnt_nxt = tx_cnt_r - 12'h001;
      end else begin
         tx_cnt_nxt = BITC;
         tx_bit_nxt = tx_bit_r + 4'h1;
         tx_sh_nxt = {1'b1, tx_sh_r[9:1]};
         tx_nxt = tx_sh_r[1];
         tx_busy_nxt = tx_bit_r != 4'h9;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rx_busy_r <= 1'b0;
         rx_cnt_r <= 12'h000;
         rx_bit_r <= 4'h0;
         rx_sh_r <= 8'h00;
         fr_idx_r <= 8'h00;
         fr_hi_r <= 8'h00;
         fr_pos_r <= 2'h0;
         tx_busy_r <= 1'b0;
         tx_cnt_r <= 12'h000;
         tx_bit_r <= 4'h0;
         tx_sh_r <= 10'h3FF;
         tx_r <= 1'b1;
      end else begin
         rx_busy_r <= rx_busy_nxt;
         rx_cnt_r <= rx_cnt_nxt;
         rx_bit_r <= rx_bit_nxt;
         rx_sh_r <= rx_sh_nxt;
         fr_idx_r <= fr_idx_nxt;
         fr_hi_r <= fr_hi_nxt;
         fr_pos_r <= fr_pos_nxt;
         tx_busy_r <= tx_busy_nxt;
         tx_cnt_r <= tx_cnt_nxt;
         tx_bit_r <= tx_bit_nxt;
         tx_sh_r <= tx_sh_nxt;
         tx_r <= tx_nxt;
      end
   end

   // ------------- divider: pwm period, full-scale duty, angle step -------
   sdms_div_e dv_st_r, dv_st_nxt;
   logic [35:0] dv_num_r, dv_num_nxt, dv_q_r, dv_q_nxt;
   logic [19:0] dv_den_r, dv_den_nxt;
   logic [20:0] dv_rem_r, dv_rem_nxt, rem_sh;
   logic [5:0] dv_cnt_r, dv_cnt_nxt;
   logic [19:0] period_r, period_nxt, fs_r, fs_nxt;
   logic [15:0] inc_r, inc_nxt, rate_eff, scale_eff;
   logic [35:0] q_new;

   assign dv_busy = dv_st_r != DV_IDLE;
   // rate clamped into the usable range, so the real rate can differ
   assign rate_eff = (rate_r > RATE_MAX) ? RATE_MAX :
                     (rate_r < RATE_MIN) ? RATE_MIN : rate_r;
   assign scale_eff = (scale_r > SCALE_MAX) ? SCALE_MAX : scale_r;
   assign rem_sh = {dv_rem_r[19:0], dv_num_r[35]};
   assign q_new = {dv_q_r[34:0], rem_sh >= {1'b0, dv_den_r}};

   always_comb begin
      dv_st_nxt = dv_st_r;
      dv_num_nxt = dv_num_r;
      dv_den_nxt = dv_den_r;
      dv_rem_nxt = dv_rem_r;
      dv_q_nxt = dv_q_r;
      dv_cnt_nxt = dv_cnt_r;
      period_nxt = period_r;
      fs_nxt = fs_r;
      inc_nxt = inc_r;
      case (dv_st_r)
         DV_IDLE: begin
            if (dirty_r) begin
               dv_st_nxt = DV_PER;
               dv_num_nxt = 36'(CLK_HZ);
               dv_den_nxt = {4'h0, rate_eff};
               dv_rem_nxt = '0;
               dv_cnt_nxt = 6'(DIV_W);
            end
         end
         DV_PER, DV_FS, DV_INC: begin
            dv_rem_nxt = (rem_sh >= {1'b0, dv_den_r}) ?
                         rem_sh - {1'b0, dv_den_r} : rem_sh;
            dv_q_nxt = q_new;
            dv_num_nxt = {dv_num_r[34:0], 1'b0};
            dv_cnt_nxt = dv_cnt_r - 6'h01;
            if (dv_cnt_r == 6'h01) begin
               dv_rem_nxt = '0;
               dv_cnt_nxt = 6'(DIV_W);
               if (dv_st_r == DV_PER) begin
                  period_nxt = q_new[19:0];
                  dv_num_nxt = 36'(q_new[19:0] * scale_eff);
                  dv_den_nxt = 20'(SCALE_MAX);
                  dv_st_nxt = DV_FS;
               end else if (dv_st_r == DV_FS) begin
                  fs_nxt = q_new[19:0];
                  dv_num_nxt = QUARTER_TURN;
                  dv_den_nxt = {12'h000, sub_r};
                  dv_st_nxt = DV_INC;
               end else begin
                  inc_nxt = q_new[15:0];
                  dv_st_nxt = DV_IDLE;
               end
            end
         end
         default: dv_st_nxt = DV_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         dv_st_r <= DV_IDLE;
         dv_num_r <= '0;
         dv_den_r <= 20'h00001;
         dv_rem_r <= '0;
         dv_q_r <= '0;
         dv_cnt_r <= 6'h00;
         period_r <= 20'h00001;
         fs_r <= 20'h00000;
         inc_r <= 16'h0000;
      end else begin
         dv_st_r <= dv_st_nxt;
         dv_num_r <= dv_num_nxt;
         dv_den_r <= dv_den_nxt;
         dv_rem_r <= dv_rem_nxt;
         dv_q_r <= dv_q_nxt;
         dv_cnt_r <= dv_cnt_nxt;
         period_r <= period_nxt;
         fs_r <= fs_nxt;
         inc_r <= inc_nxt;
      end
   end

   // ---------------- phase index and coil pwm ----------------
   logic [8:0] idx_nxt, seq_last;
   logic [19:0] cnt_r, cnt_nxt, duty_a, duty_b;
   logic [17:0] ang;
   logic [8:0] va, vb;
   logic [3:0] hp;
   logic drv_r, apwm_r, bpwm_r, aneg_r, bneg_r;
   logic drv_nxt, apwm_nxt, bpwm_nxt, aneg_nxt, bneg_nxt;
   logic [1:0] mode_d_r;
   logic [7:0] sub_d_r;

   always_comb begin
      case (mode_r)
         MODE_FULL: seq_last = 9'h003;
         MODE_HALF: seq_last = 9'h007;
         default: seq_last = {sub_r[6:0], 2'b00} - 9'h001;
      endcase
      idx_nxt = idx_r;
      if (mode_r != mode_d_r || sub_r != sub_d_r) begin
         idx_nxt = 9'h000;
      end else if (step_acc) begin
         if (s2_r[2]) begin
            idx_nxt = (idx_r >= seq_last) ? 9'h000 : idx_r + 9'h001;
         end else begin
            idx_nxt = (idx_r == 9'h000 || idx_r > seq_last) ? seq_last
                      : idx_r - 9'h001;
         end
      end
      ang = 18'(idx_r * inc_r);
      hp = half_pat((mode_r == MODE_FULL) ? {idx_r[1:0], 1'b1} : idx_r[2:0]);
      if (mode_r == MODE_MICRO) begin
         va = coil_val(ang[17:16], ang[15:12]);
         vb = coil_val(ang[17:16] + 2'h1, ang[15:12]);
      end else begin
         va = {hp[2], {8{hp[3]}}};
         vb = {hp[0], {8{hp[1]}}};
      end
      duty_a = 20'((28'(fs_r) * va[7:0]) >> 8);
      duty_b = 20'((28'(fs_r) * vb[7:0]) >> 8);
      cnt_nxt = (cnt_r + 20'h00001 >= period_r) ? 20'h00000
                : cnt_r + 20'h00001;
      drv_nxt = s2_r[0];
      apwm_nxt = s2_r[0] && cnt_r < duty_a;
      bpwm_nxt = s2_r[0] && cnt_r < duty_b;
      aneg_nxt = va[8];
      bneg_nxt = vb[8];
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         idx_r <= 9'h000;
         mode_d_r <= MODE_FULL;
         sub_d_r <= SUB_RST;
         cnt_r <= 20'h00000;
         drv_r <= 1'b0;
         apwm_r <= 1'b0;
         bpwm_r <= 1'b0;
         aneg_r <= 1'b0;
         bneg_r <= 1'b0;
      end else begin
         idx_r <= idx_nxt;
         mode_d_r <= mode_r;
         sub_d_r <= sub_r;
         cnt_r <= cnt_nxt;
         drv_r <= drv_nxt;
         apwm_r <= apwm_nxt;
         bpwm_r <= bpwm_nxt;
         aneg_r <= aneg_nxt;
         bneg_r <= bneg_nxt;
      end
   end

   assign tx_line = tx_r;
   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign nv_we = nv_we_r;
   assign nv_wdata = nv_wdata_r;
   assign drive_on = drv_r;
   assign coil_a_pwm = apwm_r;
   assign coil_a_neg = aneg_r;
   assign coil_b_pwm = bpwm_r;
   assign coil_b_neg = bneg_r;
endmodule

// ---- sdms_top_monitor.sv ----
// checker for the coil sequencer ports: apb handshake, store pulse, drive
// assumes one clock domain, nrst async active low
`timescale 1ns/1ns
module sdms_top_monitor import sdms_pkg::*; #(
   parameter int BIT_CYCLES = BIT_CYC
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic drive_allow,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic nv_we,
   input wire logic drive_on,
   input wire logic coil_a_pwm,
   input wire logic coil_b_pwm
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);
   logic acc;
   logic bad;
   assign acc = psel && penable && pready;
   assign bad = (paddr > 8'h10) || (paddr[1:0] != 2'h0);
   sequence store_wr;
      acc && pwrite && paddr == ADDR_CTRL && pwdata[CTRL_STORE_BIT];
   endsequence
   ready_first_a: assert property ((psel && !penable) ##1 (psel && penable)
      |-> pready) else $error("no ready in first access cycle");
   ready_once_a: assert property (pready |=> !pready)
      else $error("ready held past one cycle");
   err_bad_a: assert property (acc && bad |-> pslverr)
      else $error("bad address not refused");
   err_good_a: assert property (acc && !bad |-> !pslverr)
      else $error("good address refused");
   store_req_a: assert property (store_wr |-> ##[1:3] nv_we)
      else $error("store request gave no store pulse");
   store_once_a: assert property (nv_we |=> !nv_we)
      else $error("store pulse longer than one cycle");
   drive_off_a: assert property (!drive_allow [*4] |-> !drive_on)
      else $error("drive on while enable low");
   drive_on_a: assert property (drive_allow [*4] ##0 $past(nrst, 4)
      |-> drive_on) else $error("drive off while enable high");
   coil_quiet_a: assert property (!drive_on && !$past(drive_on)
      |-> !coil_a_pwm && !coil_b_pwm)
      else $error("coil pwm while disabled");
   cover property (store_wr);
   cover property (acc && bad);
   cover property ($fell(drive_on));
endmodule
bind sdms_top sdms_top_monitor #(.BIT_CYCLES(BIT_CYCLES)) u_mon (
   .clk(clk), .nrst(nrst), .drive_allow(drive_allow), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .pready(pready), .pslverr(pslverr), .nv_we(nv_we),
   .drive_on(drive_on), .coil_a_pwm(coil_a_pwm), .coil_b_pwm(coil_b_pwm));

// ---- step_dir_motor_sequencer_tb.sv ----
// self-checking bench for the coil sequencer
// assumes the controller model on step inputs and an apb master task
`timescale 1ns/1ns
module step_dir_motor_sequencer_tb import sdms_pkg::*;;
   logic clk = 1'b0, nrst = 1'b0, en = 1'b1, dir = 1'b1, req = 1'b0;
   logic [7:0] n = 8'h00;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rq;
   logic pready, pslverr, re, tx_line, nv_we, drive_on, busy;
   logic drive_allow, step_pulse, rot_cw;
   logic coil_a_pwm, coil_a_neg, coil_b_pwm, coil_b_neg;
   logic [CFG_W-1:0] nv_wdata;
   int fails = 0, n_checks = 0;
   int n_store = 0;
   logic rx = 1'b1;
   localparam int BIT_T = 16;
   localparam int DUTY = CLK_HZ / RATE_RST * SCALE_RST / SCALE_MAX *
      255 / 256;
   sdms_ctrl_model ctrl (.clk(clk), .nrst(nrst), .en(en), .dir(dir),
      .req(req), .n(n), .drive_allow(drive_allow),
      .step_pulse(step_pulse), .rot_cw(rot_cw), .busy(busy));
   sdms_top #(.BIT_CYCLES(BIT_T)) dut (.clk(clk), .nrst(nrst),
      .drive_allow(drive_allow), .step_pulse(step_pulse), .rot_cw(rot_cw),
      .rx_line(rx), .tx_line(tx_line), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .nv_valid(1'b0),
      .nv_rdata({CFG_W{1'b0}}), .nv_we(nv_we), .nv_wdata(nv_wdata),
      .drive_on(drive_on), .coil_a_pwm(coil_a_pwm), .coil_a_neg(coil_a_neg),
      .coil_b_pwm(coil_b_pwm), .coil_b_neg(coil_b_neg));
   initial begin
      forever #25 clk = ~clk;
   end
   always @(posedge clk) begin
      if (nv_we === 1'b1) begin
         n_store <= n_store + 1;
      end
   end
   task final_report;
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task chk(input string nm, input logic [63:0] e, input logic [63:0] g);
      n_checks++;
      if (g !== e) begin
         fails++;
         $display("unexpected %s exp %h got %h", nm, e, g);
      end
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rq = prdata;
      re = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task steps(input logic d, input logic [7:0] k);
      dir <= d;
      repeat (3) @(posedge clk);
      n <= k;
      req <= 1'b1;
      @(posedge clk);
      req <= 1'b0;
      @(posedge clk);
      while (busy === 1'b1) begin
         @(posedge clk);
      end
      repeat (8) @(posedge clk);
   endtask
   task idx(input logic [8:0] e);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk("index", e, rq[8:0]);
   endtask
   task t_defaults;
      apb(1'b0, ADDR_CTRL, 32'h0);
      chk("mode", MODE_FULL, rq[1:0]);
      apb(1'b0, ADDR_RATE, 32'h0);
      chk("rate", RATE_RST, rq[15:0]);
      apb(1'b0, ADDR_SCALE, 32'h0);
      chk("scale", SCALE_RST, rq[15:0]);
      apb(1'b0, ADDR_SUBSTEP, 32'h0);
      chk("substeps", SUB_RST, rq[7:0]);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk("allowed", 1'b1, rq[9]);
      apb(1'b0, 8'h14, 32'h0);
      chk("err", 1'b1, re);
      apb(1'b1, 8'h06, 32'h1);
      chk("err", 1'b1, re);
      apb(1'b1, ADDR_STATUS, 32'h1);
      chk("err", 1'b0, re);
      apb(1'b0, ADDR_CTRL, 32'h0);
      chk("status ro", MODE_FULL, rq[1:0]);
      $display("test defaults done");
   endtask
   task t_full;
      int hi;
      for (int k = 1; k <= 5; k++) begin
         steps(1'b1, 8'h01);
         chk("a_neg", k % 4 == 1 || k % 4 == 2, coil_a_neg);
         chk("b_neg", k % 4 >= 2, coil_b_neg);
      end
      // high cycles of both coils over one pwm period
      hi = 0;
      repeat (CLK_HZ / RATE_RST) begin
         @(posedge clk);
         hi += coil_a_pwm + coil_b_pwm;
      end
      chk("duty", 2 * DUTY, hi);
      idx(9'h001);
      steps(1'b0, 8'h02);
      idx(9'h003);
      chk("a_neg", 1'b0, coil_a_neg);
      chk("b_neg", 1'b1, coil_b_neg);
      $display("test full done");
   endtask
   task t_disabled;
      en <= 1'b0;
      repeat (6) @(posedge clk);
      steps(1'b1, 8'h03);
      idx(9'h003);
      chk("drive_on", 1'b0, drive_on);
      chk("pwm", 2'h0, {coil_a_pwm, coil_b_pwm});
      en <= 1'b1;
      repeat (6) @(posedge clk);
      $display("test disabled done");
   endtask
   task t_half;
      apb(1'b1, ADDR_CTRL, {30'h0, MODE_HALF});
      idx(9'h000);
      steps(1'b1, 8'h08);
      idx(9'h000);
      steps(1'b0, 8'h01);
      idx(9'h007);
      apb(1'b1, ADDR_CTRL, 32'h3);
      apb(1'b0, ADDR_CTRL, 32'h0);
      chk("mode", MODE_HALF, rq[1:0]);
      $display("test half done");
   endtask
   task t_micro;
      apb(1'b1, ADDR_SUBSTEP, 32'hD);
      apb(1'b0, ADDR_SUBSTEP, 32'h0);
      chk("substeps", SUB_RST, rq[7:0]);
      apb(1'b1, ADDR_CTRL, {30'h0, MODE_MICRO});
      steps(1'b0, 8'h01);
      idx(9'h01F);
      apb(1'b1, ADDR_SUBSTEP, 32'h80);
      apb(1'b0, ADDR_SUBSTEP, 32'h0);
      chk("substeps", 8'h80, rq[7:0]);
      steps(1'b0, 8'h01);
      idx(9'h1FF);
      $display("test micro done");
   endtask
   task t_store;
      // settings above were exercised before being kept
      apb(1'b1, ADDR_CTRL, {29'h0, 1'b1, MODE_MICRO});
      @(posedge clk);
      chk("store", 1, n_store);
      chk("image", {MODE_MICRO, RATE_RST, SCALE_RST, 8'h80}, nv_wdata);
      apb(1'b0, ADDR_CTRL, 32'h0);
      chk("ctrl", {1'b0, MODE_MICRO}, rq[2:0]);
      $display("test store done");
   endtask
   task ser_byte(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int j = 0; j < 10; j++) begin
         rx <= f[j];
         repeat (BIT_T) @(posedge clk);
      end
   endtask
   task t_serial;
      logic [7:0] ack;
      ser_byte(8'h01);
      ser_byte(8'h0F);
      ser_byte(8'hA0);
      chk("ack start", 1'b0, tx_line);
      for (int j = 0; j < 8; j++) begin
         repeat (BIT_T) @(posedge clk);
         ack[j] = tx_line;
      end
      chk("ack", 8'h01, ack);
      apb(1'b0, ADDR_RATE, 32'h0);
      chk("serial rate", 16'h0FA0, rq[15:0]);
      $display("test serial done");
   endtask
   initial begin
      repeat (10) @(posedge clk);
      nrst <= 1'b1;
      repeat (4) @(posedge clk);
      t_defaults();
      t_full();
      t_disabled();
      t_half();
      t_micro();
      t_store();
      t_serial();
      final_report();
   end
   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      final_report();
   end
endmodule
